// [current_share_group_config.sv]
// Share group setup registers, master election, broadcast enable and restart
`timescale 1ns/100ps
// Functional notes
// - Surviving members keep running when others in the group fault.
// - A faulted member is never rejoined or restarted on its own.
// - With restart response, whole group restarts only after all members faulted.
// - Lowest configured position is master at group start.
// - Master sends load current information to all slaves.
// - When master drops or faults, next lowest position takes over.
// - Transmit block bit 5 low permits group bus traffic; resets low.
// - Rail identity bits 4:0 tag sequencing and fault traffic.
// - Bits 7:5 hold member count minus one.
// - Bits 4:2 hold position, zero being the master.
// - Share setup bit 0 set enables current sharing.
// - Bus enable with broadcast on is relayed to same broadcast group.
module current_share_group_config (
    input  wire logic                   clk,            // System clock, 50 MHz
    input  wire logic                   rst,            // Sync reset, active high
    input  wire share_pkg::reg_req_t    reg_req,        // Management bus register access
    output logic [15:0]                 reg_rdata,      // Read data, registered
    output logic                        reg_rvalid,     // Read data valid pulse
    input  wire logic                   bcast_en_cfg,   // Broadcast enable configured
    input  wire logic                   restart_cfg,    // Fault response set to restart
    input  wire logic                   mgmt_enable,    // Enable command pulse from bus
    input  wire logic                   local_fault,    // Own fault shutdown pulse
    input  wire logic [15:0]            load_current,   // Own measured load current
    input  wire share_pkg::gcb_msg_t    gcb_rx,         // Message received on group bus
    input  wire logic [7:0]             peer_drop,      // Peer position fault/drop pulses
    output share_pkg::gcb_msg_t         gcb_tx,         // Message to send on group bus
    output logic                        output_on,      // Regulator output running
    output logic                        is_master,      // This member is master phase
    output logic [15:0]                 share_target    // Current target from master
);
    import share_pkg::*;

    logic [15:0]        gbus_q;
    logic [15:0]        gbus_d;
    logic [15:0]        share_q;
    logic [15:0]        share_d;
    logic [15:0]        rdata_q;
    logic [15:0]        rdata_d;
    logic               rvalid_q;
    logic               rvalid_d;
    member_state_t      state_q;
    member_state_t      state_d;
    gcb_msg_t           tx_q;
    gcb_msg_t           tx_d;
    logic [15:0]        target_q;
    logic [15:0]        target_d;
    logic               load_group;
    logic [MEMBERS-1:0] drop_vec;
    logic [MEMBERS-1:0] alive;
    logic [2:0]         lowest;
    logic               none_alive;

    // Field views of the two setup words
    logic [4:0] bcast_group;
    logic       tx_block;
    logic [4:0] rail_id;
    logic [2:0] count_m1;
    logic [2:0] position;
    logic       share_on;
    logic       enable_seen;
    logic       restart_seen;

    assign bcast_group = gbus_q[GB_BCAST_LO +: 5];
    assign tx_block    = gbus_q[GB_TXBLK];
    assign rail_id     = gbus_q[GB_RAIL_LO +: 5];
    assign count_m1    = share_q[SH_COUNT_LO +: 3];
    assign position    = share_q[SH_POS_LO +: 3];
    assign share_on    = share_q[SH_ENABLE];

    // Enable arrives locally or relayed from our broadcast group
    assign enable_seen  = mgmt_enable
                        | (gcb_rx.valid && gcb_rx.kind == MSG_ENABLE
                           && bcast_en_cfg && gcb_rx.tag == bcast_group);
    assign restart_seen = gcb_rx.valid && gcb_rx.kind == MSG_RESTART
                        && gcb_rx.tag == rail_id;

    // Register writes; all bits stored, reserved ones included
    always_comb begin
        gbus_d   = gbus_q;
        share_d  = share_q;
        rdata_d  = rdata_q;
        rvalid_d = 1'b0;
        if (reg_req.wr) begin
            if (reg_req.sel == SEL_GROUP_BUS) begin
                gbus_d = reg_req.wdata;
            end else begin
                share_d = reg_req.wdata;
            end
        end
        if (reg_req.rd) begin
            rdata_d  = (reg_req.sel == SEL_GROUP_BUS) ? gbus_q : share_q;
            rvalid_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            gbus_q   <= GROUP_BUS_RESET;
            share_q  <= SHARE_RESET;
            rdata_q  <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            gbus_q   <= gbus_d;
            share_q  <= share_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // Group (re)start reloads the alive set of all configured members
    assign load_group = (state_d == ST_RUN) && (state_q != ST_RUN);

    // Own fault counts as our own position dropping out
    always_comb begin
        drop_vec = peer_drop;
        if (local_fault) begin
            drop_vec[position] = 1'b1;
        end
    end

    member_tracker u_tracker (
        .clk        (clk),
        .rst        (rst),
        .load       (load_group),
        .count_m1   (count_m1),
        .drop       (drop_vec),
        .alive      (alive),
        .lowest     (lowest),
        .none_alive (none_alive)
    );

    // Member state: idle until enabled, run, fault, group restart
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (enable_seen) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (local_fault) begin
                    state_d = ST_FAULTED;
                end
            end
            ST_FAULTED: begin
                if (restart_cfg && (none_alive || restart_seen)) begin
                    state_d = ST_RESTART;
                end
            end
            ST_RESTART: begin
                state_d = ST_RUN;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Transmit: relay enable, master current, restart; blocked by tx bit
    always_comb begin
        tx_d     = '0;
        target_d = target_q;
        if (!tx_block) begin
            if (mgmt_enable && bcast_en_cfg) begin
                tx_d.valid = 1'b1;
                tx_d.kind  = MSG_ENABLE;
                tx_d.tag   = bcast_group;
            end else if (state_q == ST_RESTART && none_alive) begin
                tx_d.valid = 1'b1;
                tx_d.kind  = MSG_RESTART;
                tx_d.tag   = rail_id;
            end else if (is_master) begin
                tx_d.valid   = 1'b1;
                tx_d.kind    = MSG_CURRENT;
                tx_d.tag     = rail_id;
                tx_d.payload = load_current;
            end
        end
        // Slaves follow the master's current, master follows its own
        if (is_master) begin
            target_d = load_current;
        end else if (gcb_rx.valid && gcb_rx.kind == MSG_CURRENT
                     && gcb_rx.tag == rail_id) begin
            target_d = gcb_rx.payload;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q  <= ST_IDLE;
            tx_q     <= '0;
            target_q <= 16'h0000;
        end else begin
            state_q  <= state_d;
            tx_q     <= tx_d;
            target_q <= target_d;
        end
    end

    assign is_master    = share_on && (state_q == ST_RUN) && alive[position]
                        && (lowest == position);
    assign output_on    = (state_q == ST_RUN);
    assign gcb_tx       = tx_q;
    assign share_target = target_q;
    assign reg_rdata    = rdata_q;
    assign reg_rvalid   = rvalid_q;
endmodule

// [share_pkg.sv]
// Package: register layouts, commands and states for the share group block
package share_pkg;

    // Register selectors on the management command port
    localparam logic [0:0] SEL_GROUP_BUS = 1'h0;
    localparam logic [0:0] SEL_SHARE     = 1'h1;

    // Reset values: transmit allowed, sharing off, position 0
    localparam logic [15:0] GROUP_BUS_RESET = 16'h0000;
    localparam logic [15:0] SHARE_RESET     = 16'h0000;

    // Group bus setup word fields
    localparam int GB_BCAST_LO = 8;
    localparam int GB_TXBLK    = 5;
    localparam int GB_RAIL_LO  = 0;

    // Share setup word fields
    localparam int SH_RAIL_LO  = 8;
    localparam int SH_COUNT_LO = 5;
    localparam int SH_POS_LO   = 2;
    localparam int SH_ENABLE   = 0;

    localparam int MEMBERS = 8;

    // Group bus message kinds
    typedef enum logic [1:0] {
        MSG_NONE,
        MSG_ENABLE,
        MSG_CURRENT,
        MSG_RESTART
    } msg_kind_t;

    // Register write/read request from the management bus
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [0:0]  sel;
        logic [15:0] wdata;
    } reg_req_t;

    // One message on the group control bus
    typedef struct packed {
        logic        valid;
        msg_kind_t   kind;
        logic [4:0]  tag;     // broadcast group or rail identity
        logic [15:0] payload;
    } gcb_msg_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_FAULTED,
        ST_RESTART
    } member_state_t;

endpackage

// [member_tracker.sv]
// Tracks which group positions are still operating and picks the lowest
`timescale 1ns/100ps
module member_tracker (
    input  wire logic                              clk,        // System clock
    input  wire logic                              rst,        // Sync reset, active high
    input  wire logic                              load,       // Group start: mark members up
    input  wire logic [2:0]                        count_m1,   // Member count minus one
    input  wire logic [share_pkg::MEMBERS-1:0]     drop,       // Per-position drop pulses
    output logic      [share_pkg::MEMBERS-1:0]     alive,      // Positions still operating
    output logic      [2:0]                        lowest,     // Lowest alive position
    output logic                                   none_alive  // Every member is down
);
    import share_pkg::*;

    logic [MEMBERS-1:0] alive_d;
    logic [MEMBERS-1:0] alive_q;

    // Lowest set bit; used for the master election
    function automatic logic [2:0] lowest_set(input logic [MEMBERS-1:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = MEMBERS - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // Next alive set: load marks positions 0..count_m1, drops clear; load wins
    always_comb begin
        alive_d = alive_q & ~drop;
        if (load) begin
            for (int i = 0; i < MEMBERS; i++) begin
                alive_d[i] = (3'(i) <= count_m1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            alive_q <= '0;
        end else begin
            alive_q <= alive_d;
        end
    end

    assign alive      = alive_q;
    assign lowest     = lowest_set(alive_q);
    assign none_alive = (alive_q == '0);
endmodule

// [share_group_chk.sv]
// Port checker for the share group block
`timescale 1ns/100ps
module share_group_chk
    import share_pkg::*;
(
    input wire logic                clk,          // Clock
    input wire logic                rst,          // Reset
    input wire share_pkg::reg_req_t reg_req,      // Access
    input wire logic                reg_rvalid,   // Read valid
    input wire logic                bcast_en_cfg, // Broadcast on
    input wire logic                restart_cfg,  // Restart on
    input wire logic                mgmt_enable,  // Enable
    input wire logic                local_fault,  // Own fault
    input wire logic [15:0]         load_current, // Current
    input wire logic [7:0]          peer_drop,    // Drops
    input wire share_pkg::gcb_msg_t gcb_tx,       // Bus out
    input wire logic                output_on,    // Running
    input wire logic                is_master     // Master
);
    logic [15:0] gb_q, gb_d, sh_q, sh_d;
    // Shadow words, so the properties know position and transmit block
    always_comb begin
        gb_d = (reg_req.wr && reg_req.sel == SEL_GROUP_BUS) ? reg_req.wdata : gb_q;
        sh_d = (reg_req.wr && reg_req.sel == SEL_SHARE) ? reg_req.wdata : sh_q;
        if (rst) begin
            gb_d = GROUP_BUS_RESET;
            sh_d = SHARE_RESET;
        end
    end
    always_ff @(posedge clk) begin
        gb_q <= gb_d;
        sh_q <= sh_d;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Start command, and the relayed enable one cycle later
    sequence s_go; mgmt_enable && bcast_en_cfg && sh_q[0] && !gb_q[5] && !output_on; endsequence
    sequence s_relay; gcb_tx.valid && gcb_tx.kind == MSG_ENABLE && gcb_tx.tag == gb_q[12:8]; endsequence
    property p_rvalid; reg_rvalid == $past(reg_req.rd); endproperty
    property p_relay; s_go |=> s_relay and output_on; endproperty
    property p_start; s_go |=> ##1 (is_master == (sh_q[4:2] == 3'h0)); endproperty
    property p_takeover;
        output_on && !local_fault && sh_q[4:2] != 3'h0
            && peer_drop == (8'h01 << sh_q[4:2]) - 8'h01 |=> is_master;
    endproperty
    property p_current;
        is_master && !gb_q[5] && !mgmt_enable && !local_fault |=> gcb_tx.valid
            && gcb_tx.kind == MSG_CURRENT && gcb_tx.payload == $past(load_current);
    endproperty
    property p_tx_block; gb_q[5] && $past(gb_q[5]) |-> !gcb_tx.valid; endproperty
    property p_fault_hold; local_fault && !restart_cfg |=> !output_on [*8]; endproperty
    property p_keep_run; output_on && !local_fault && peer_drop != 8'h00 |=> output_on; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read valid timing");
    a_relay: assert property (p_relay) else $error("enable not relayed");
    a_start: assert property (p_start) else $error("wrong start master");
    a_takeover: assert property (p_takeover) else $error("no takeover");
    a_current: assert property (p_current) else $error("master current missing");
    a_tx_block: assert property (p_tx_block) else $error("sent while blocked");
    a_fault_hold: assert property (p_fault_hold) else $error("faulted unit back");
    a_keep_run: assert property (p_keep_run) else $error("survivor stopped");
endmodule

// [peer_group_model.sv]
// Peer regulators on the group bus
`timescale 1ns/100ps
module peer_group_model
    import share_pkg::*;
(
    input  wire logic                 clk,      // Clock
    input  wire logic                 rst,      // Reset
    input  wire logic                 send,     // Send now
    input  wire share_pkg::msg_kind_t kind,     // Kind
    input  wire logic [4:0]           tag,      // Group tag
    input  wire logic [15:0]          pay,      // Message payload
    input  wire logic [7:0]           drop,     // Drops
    output share_pkg::gcb_msg_t       gcb_rx,   // To block
    output logic [7:0]                peer_drop // Drop pulses
);
    gcb_msg_t rx_d;
    // Idle bus toggles, so stale content never passes for a message
    always_comb begin
        rx_d = rst ? '0 : {1'b0, ~gcb_rx[22:0]};
        // peers send the tag that the bench drives, broadcast group or rail identity
        // peers keep alike settings, sending whatever tag the bench drives
        if (send) begin
            rx_d = {1'b1, kind, tag, pay};
        end
    end
    // Messages and drops last one cycle
    always_ff @(posedge clk) begin
        gcb_rx    <= rx_d;
        peer_drop <= drop;
    end
endmodule

// [current_share_group_config_tb.sv]
// Self-checking bench for the share group block
`timescale 1ns/100ps
module current_share_group_config_tb;
    import share_pkg::*;
    logic        clk, rst, bcast_en_cfg, restart_cfg, mgmt_enable, local_fault;
    logic        reg_rvalid, output_on, is_master, send;
    logic [15:0] load_current, reg_rdata, d, share_target, pay;
    logic [4:0]  tag;
    msg_kind_t   kind;
    logic [7:0]  peer_drop, drop;
    reg_req_t    reg_req;
    gcb_msg_t    gcb_rx, gcb_tx;
    logic [15:0] exp_q[$];
    int          n_mismatch, checks_done;
    current_share_group_config u_current_share_group_config (.clk(clk), .rst(rst),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .bcast_en_cfg(bcast_en_cfg), .restart_cfg(restart_cfg), .mgmt_enable(mgmt_enable),
        .local_fault(local_fault), .load_current(load_current), .gcb_rx(gcb_rx),
        .peer_drop(peer_drop), .gcb_tx(gcb_tx), .output_on(output_on),
        .is_master(is_master), .share_target(share_target));
    peer_group_model u_peer_group_model (.clk(clk), .rst(rst), .send(send),
        .kind(kind), .tag(tag), .pay(pay), .drop(drop),
        .gcb_rx(gcb_rx), .peer_drop(peer_drop));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Register access: one sampling edge with the request, then one idle edge
    task automatic acc(input logic w, input logic sel, input logic [15:0] v);
        if (!w) exp_q.push_back(v);
        reg_req = {w, !w, sel, w ? v : 16'h0000};
        cyc(1);
        reg_req = '0;
        cyc(1);
    endtask
    // One-cycle pulses of peer message, own fault, enable and drops
    task automatic pulse(input logic [2:0] m, input logic [7:0] dr);
        {send, local_fault, mgmt_enable} = m;
        drop = dr;
        cyc(1);
        {send, local_fault, mgmt_enable} = 3'b000;
        drop = 8'h00;
    endtask
    // Bounded wait for the output to come up
    task automatic wait_on;
        for (int i = 0; i < 20 && output_on !== 1'b1; i++) begin
            cyc(1);
        end
        check({15'h0000, output_on}, 16'h0001);
        if (output_on !== 1'b1) begin
            test_done();
        end
    endtask
    // Read answers are matched to the oldest note at mid-cycle
    always @(negedge clk) begin
        if (reg_rvalid === 1'b1) begin
            check(reg_rdata, exp_q.pop_front());
        end
    end
    initial begin
        rst = 1'b1;
        reg_req = '0;
        bcast_en_cfg = 1'b1;
        restart_cfg = 1'b0;
        kind = MSG_ENABLE;
        tag = 5'h04;
        pay = 16'h0000;
        pulse(3'b000, 8'h00);
        load_current = 16'h0000;
        n_mismatch = 0;
        checks_done = 0;
        void'($urandom(32'hB247));
        cyc(19);
        rst = 1'b0;
        acc(1'b0, SEL_GROUP_BUS, GROUP_BUS_RESET);
        acc(1'b0, SEL_SHARE, SHARE_RESET);
        repeat (4) begin
            d = 16'($urandom);
            acc(1'b1, SEL_GROUP_BUS, d);
            acc(1'b0, SEL_GROUP_BUS, d);
        end
        // Two members, this one at position 1, broadcast group 4, rail 7
        // reserved bits zero, both rail identity fields hold 7
        acc(1'b1, SEL_GROUP_BUS, 16'h0407);
        acc(1'b1, SEL_SHARE, 16'h0725);
        acc(1'b0, SEL_SHARE, 16'h0725);
        load_current = 16'($urandom);
        pulse(3'b001, 8'h00);
        check(16'({gcb_tx.valid, gcb_tx.kind, gcb_tx.tag}), 16'({1'b1, MSG_ENABLE, 5'h04}));
        cyc(1);
        check({15'h0000, is_master}, 16'h0000);
        // A slave follows the current that the master sends on the group bus
        kind = MSG_CURRENT;
        tag = 5'h07;
        pay = 16'($urandom);
        pulse(3'b100, 8'h00);
        cyc(1);
        check(share_target, pay);
        pulse(3'b000, 8'h01);
        cyc(1);
        check({14'h0000, output_on, is_master}, 16'h0003);
        cyc(1);
        check(gcb_tx.payload, load_current);
        check(share_target, load_current);
        kind = MSG_ENABLE;
        tag = 5'h04;
        acc(1'b1, SEL_GROUP_BUS, 16'h0427);
        cyc(1);
        check({15'h0000, gcb_tx.valid}, 16'h0000);
        // Own fault: a peer enable must not bring it back
        pulse(3'b010, 8'h00);
        cyc(1);
        pulse(3'b100, 8'h00);
        cyc(4);
        check({15'h0000, output_on}, 16'h0000);
        // Three members, position 0, restart response, started by a peer
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        restart_cfg = 1'b1;
        acc(1'b1, SEL_GROUP_BUS, 16'h0407);
        acc(1'b1, SEL_SHARE, 16'h0741);
        pulse(3'b100, 8'h00);
        wait_on();
        cyc(1);
        check({15'h0000, is_master}, 16'h0001);
        pulse(3'b010, 8'h00);
        cyc(3);
        check({15'h0000, output_on}, 16'h0000);
        pulse(3'b000, 8'h06);
        wait_on();
        check(16'({gcb_tx.valid, gcb_tx.kind, gcb_tx.tag}), 16'({1'b1, MSG_RESTART, 5'h07}));
        // A peer's group restart message brings the faulted member back
        pulse(3'b010, 8'h00);
        cyc(1);
        kind = MSG_RESTART;
        tag = 5'h07;
        pulse(3'b100, 8'h00);
        wait_on();
        // Every read must have been answered
        check(16'(exp_q.size()), 16'h0000);
        test_done();
    end
endmodule
bind current_share_group_config share_group_chk u_share_group_chk (.clk(clk), .rst(rst),
    .reg_req(reg_req), .reg_rvalid(reg_rvalid), .bcast_en_cfg(bcast_en_cfg),
    .restart_cfg(restart_cfg), .mgmt_enable(mgmt_enable), .local_fault(local_fault),
    .load_current(load_current), .peer_drop(peer_drop), .gcb_tx(gcb_tx),
    .output_on(output_on), .is_master(is_master));
